// ### src/pcie_linkstat2_pm_capability_regs.sv
`timescale 1ns/1ps
module pcie_linkstat2_pm_capability_regs
  import pcie_caps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire link_phy_t link_phy_i,
  input wire pwr_state_t pwr_state_i,
  output logic [4:0] wake_active_states_o,
  output logic wake_forward_o
);

  // word-level match; the 16-bit half within the word is sorted out by place_half
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
    hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
  endfunction

  function automatic logic [DAT_W-1:0] place_half(input logic [ADR_W-1:0] ofs,
                                                  input logic [15:0] val);
    place_half = ofs[1] ? {val, 16'h0000} : {16'h0000, val};
  endfunction

  // link-side status passes three flops; a change counts once stages two and three agree
  logic [1:0] phy_s1_reg;
  logic [1:0] phy_s2_reg;
  logic [1:0] phy_s3_reg;
  logic [1:0] phy_stable_reg;
  logic deemph_reg;
  wire logic [1:0] phy_stable_next;
  wire logic speed_5g;
  wire logic deemph_next;

  assign phy_stable_next = (phy_s2_reg == phy_s3_reg) ? phy_s3_reg : phy_stable_reg;
  assign speed_5g = phy_stable_reg[1];
  // indicator follows the link only at 5G; at 2.5G it holds its last value
  assign deemph_next = speed_5g ? phy_stable_reg[0] : deemph_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phy_s1_reg <= 2'h0;
      phy_s2_reg <= 2'h0;
      phy_s3_reg <= 2'h0;
      phy_stable_reg <= 2'h0;
      deemph_reg <= LINK_STATUS_TWO_RST[CUR_DEEMPH_BIT];
    end
    else
    begin
      phy_s1_reg <= link_phy_i;
      phy_s2_reg <= phy_s1_reg;
      phy_s3_reg <= phy_s2_reg;
      phy_stable_reg <= phy_stable_next;
      deemph_reg <= deemph_next;
    end
  end

  // bus decode
  logic ack_reg;
  logic [DAT_W-1:0] rdata_reg;
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic take_req = req && !ack_reg;
  wire logic wr_commit = req && wb_we_i && ack_reg;
  wire logic sel_lsts2 = hit(wb_adr_i, OFS_LINK_STATUS_TWO);
  wire logic sel_scap2 = hit(wb_adr_i, OFS_SLOT_CAPS_TWO);
  wire logic sel_sctl2 = hit(wb_adr_i, OFS_SLOT_CONTROL_TWO);
  wire logic sel_ssts2 = hit(wb_adr_i, OFS_SLOT_STATUS_TWO);
  wire logic sel_power_mgmt_caps = hit(wb_adr_i, OFS_POWER_MGMT_CAPS);
  wire logic sel_lock = hit(wb_adr_i, OFS_CONFIG_LOCK);

  // lock control: rewritable at any time, steers the lockable fields
  logic unlock_reg;
  wire logic lock_wr = wr_commit && sel_lock && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      unlock_reg <= UNLOCK_RST;
    else if (lock_wr)
      unlock_reg <= wb_dat_i[UNLOCK_BIT];
  end

  // lockable fields of the capability header
  wire logic pm_wr = wr_commit && sel_power_mgmt_caps;
  logic [7:0] next_ptr;
  logic [0:0] special_init;
  logic [4:0] wake_mask;

  lock_field_reg #(
    .WIDTH(8),
    .RESET_VALUE(NEXT_PTR_RST)
  ) u_next_ptr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .write_i(pm_wr && wb_sel_i[1]),
    .unlocked_i(unlock_reg),
    .data_i(wb_dat_i[NEXT_PTR_LSB +: 8]),
    .value_o(next_ptr)
  );

  lock_field_reg #(
    .WIDTH(1),
    .RESET_VALUE(SPECIAL_INIT_RST)
  ) u_special_init (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .write_i(pm_wr && wb_sel_i[2]),
    .unlocked_i(unlock_reg),
    .data_i(wb_dat_i[SPECIAL_INIT_BIT +: 1]),
    .value_o(special_init)
  );

  lock_field_reg #(
    .WIDTH(5),
    .RESET_VALUE(WAKE_MASK_RST)
  ) u_wake_mask (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .write_i(pm_wr && wb_sel_i[3]),
    .unlocked_i(unlock_reg),
    .data_i(wb_dat_i[WAKE_MASK_LSB +: 5]),
    .value_o(wake_mask)
  );

  // header image: constant fields are tied, never stored, so writes cannot touch them
  pm_caps_t pm_caps;
  assign pm_caps.capability_identifier = CAPABILITY_IDENTIFIER_VALUE;
  assign pm_caps.next_capability_pointer = next_ptr;
  assign pm_caps.pm_spec_revision = REVISION_VALUE;
  assign pm_caps.wake_event_clock_flag = 1'b0;
  assign pm_caps.rsvd20 = 1'b0;
  assign pm_caps.special_init_flag = special_init[0];
  assign pm_caps.aux_current_need = AUX_CURRENT_VALUE;
  assign pm_caps.light_sleep_support = 1'b0;
  assign pm_caps.deeper_sleep_support = 1'b0;
  assign pm_caps.wake_event_state_mask = wake_mask;

  wire logic [15:0] link_status_two = {15'h0000, deemph_reg};

  // read mux; unmapped addresses read zero
  wire logic [DAT_W-1:0] rdata_next =
    sel_lsts2 ? place_half(OFS_LINK_STATUS_TWO, link_status_two) :
    sel_scap2 ? SLOT_CAPS_TWO_RST :
    // slot control two and slot status two share one word
    (sel_sctl2 || sel_ssts2) ? (place_half(OFS_SLOT_CONTROL_TWO, SLOT_CONTROL_TWO_RST)
      | place_half(OFS_SLOT_STATUS_TWO, SLOT_STATUS_TWO_RST)) :
    sel_power_mgmt_caps ? pm_caps :
    sel_lock ? {31'h0000_0000, unlock_reg} :
    32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= take_req;
      if (take_req)
        rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // wake behaviour follows the default state set, not the advertised mask
  wire logic [2:0] pwr_idx = pwr_state_i;
  wire logic cold_off = (pwr_state_i == PWR_COLD_OFF);
  assign wake_active_states_o = WAKE_MASK_RST;
  assign wake_forward_o = (pwr_idx <= 3'h4) && WAKE_MASK_RST[pwr_idx] && !cold_off;

  a_deemph_tracks: assert property (
    @(posedge clk_i) disable iff (rst_i)
    speed_5g |=> deemph_reg == $past(phy_stable_reg[0])
  ) else $error("de-emphasis indicator does not track the link at 5G");

  a_deemph_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !speed_5g |=> $stable(deemph_reg)
  ) else $error("de-emphasis indicator moved at 2.5G");

  a_slot_caps_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_req && sel_scap2) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000)
  ) else $error("slot caps two read not zero");

  a_slot_ctl_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_req && sel_sctl2) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000)
  ) else $error("slot control two read not zero");

  a_slot_sts_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_req && sel_ssts2) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000)
  ) else $error("slot status two read not zero");

  a_pm_fixed_fields: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_req && sel_power_mgmt_caps) |=>
      (wb_dat_o[7:0] == 8'h01 && wb_dat_o[18:16] == 3'h3 && wb_dat_o[26:22] == 5'h00
       && wb_dat_o[20:19] == 2'h0)
  ) else $error("fixed capability header fields wrong");

  a_locked_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!unlock_reg && !lock_wr) |=> ($stable(next_ptr) && $stable(wake_mask) && $stable(special_init))
  ) else $error("lockable field changed while locked");

  a_unlock_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pm_wr && unlock_reg && wb_sel_i[3]) |=> wake_mask == $past(wb_dat_i[31:27])
  ) else $error("wake mask write while unlocked not taken");

  a_reset_defaults: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> (special_init == 1'b0 && wake_mask == 5'h19 && next_ptr == 8'hd0)
  ) else $error("lockable fields not at defaults after reset");

  a_cold_no_fwd: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cold_off |-> !wake_forward_o
  ) else $error("wake forwarded in cold off state");

  a_behaviour_fixed: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pm_wr && unlock_reg) |=> (wake_active_states_o == 5'h19
      && wake_forward_o == ((pwr_idx == 3'h0) || (pwr_idx == 3'h3)))
  ) else $error("wake behaviour followed the advertised mask");

  a_lsts2_reserved: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_req && sel_lsts2) |=> (wb_dat_o[31:17] == 15'h0 && wb_dat_o[15:0] == 16'h0
      && wb_dat_o[16] == $past(deemph_reg))
  ) else $error("link status two read wrong");

  a_ack_one_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take_req |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("ack not a single cycle one edge after request");

endmodule

// ### src/pcie_caps_pkg.sv
package pcie_caps_pkg;

  localparam int DAT_W = 32;
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;

  // byte offsets; a 16-bit register sits in the word half that offset bit 1 names
  localparam logic [ADR_W-1:0] OFS_LINK_STATUS_TWO = 12'h072;
  localparam logic [ADR_W-1:0] OFS_SLOT_CAPS_TWO = 12'h074;
  localparam logic [ADR_W-1:0] OFS_SLOT_CONTROL_TWO = 12'h078;
  localparam logic [ADR_W-1:0] OFS_SLOT_STATUS_TWO = 12'h07a;
  localparam logic [ADR_W-1:0] OFS_POWER_MGMT_CAPS = 12'h0c0;
  localparam logic [ADR_W-1:0] OFS_CONFIG_LOCK = 12'h3c0;

  // field positions
  localparam int CUR_DEEMPH_BIT = 0;
  localparam int CAPABILITY_IDENTIFIER_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int REVISION_LSB = 16;
  localparam int WAKE_CLK_BIT = 19;
  localparam int SPECIAL_INIT_BIT = 21;
  localparam int AUX_CURRENT_LSB = 22;
  localparam int LIGHT_SLEEP_BIT = 25;
  localparam int DEEPER_SLEEP_BIT = 26;
  localparam int WAKE_MASK_LSB = 27;
  localparam int UNLOCK_BIT = 0;

  // reset and fixed values
  localparam logic [15:0] LINK_STATUS_TWO_RST = 16'h0000;
  localparam logic [31:0] SLOT_CAPS_TWO_RST = 32'h0000_0000;
  localparam logic [15:0] SLOT_CONTROL_TWO_RST = 16'h0000;
  localparam logic [15:0] SLOT_STATUS_TWO_RST = 16'h0000;
  localparam logic [7:0] CAPABILITY_IDENTIFIER_VALUE = 8'h01;
  localparam logic [7:0] NEXT_PTR_RST = 8'hd0;
  localparam logic [2:0] REVISION_VALUE = 3'h3;
  localparam logic [0:0] SPECIAL_INIT_RST = 1'h0;
  localparam logic [2:0] AUX_CURRENT_VALUE = 3'h0;
  localparam logic [4:0] WAKE_MASK_RST = 5'h19;
  localparam logic [0:0] UNLOCK_RST = 1'h0;

  typedef enum logic [2:0] {
    PWR_FULL,
    PWR_LIGHT,
    PWR_DEEPER,
    PWR_HOT_OFF,
    PWR_COLD_OFF
  } pwr_state_t;

  typedef struct packed {
    logic [4:0] wake_event_state_mask;
    logic deeper_sleep_support;
    logic light_sleep_support;
    logic [2:0] aux_current_need;
    logic special_init_flag;
    logic rsvd20;
    logic wake_event_clock_flag;
    logic [2:0] pm_spec_revision;
    logic [7:0] next_capability_pointer;
    logic [7:0] capability_identifier;
  } pm_caps_t;

  typedef struct packed {
    logic speed_5g;
    logic current_deemph_indicator;
  } link_phy_t;

  function automatic logic [ADR_W-1:0] byte_addr(input logic [IDX_W-1:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// ### src/lock_field_reg.sv
`timescale 1ns/1ps
module lock_field_reg
  import pcie_caps_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic write_i,
  input wire logic unlocked_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] value_o
);

  logic [WIDTH-1:0] value_reg;
  wire logic take_write = write_i && unlocked_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      value_reg <= RESET_VALUE;
    else if (take_write)
      value_reg <= data_i;
  end

  assign value_o = value_reg;

endmodule

// ### dv/pcie_linkstat2_pm_capability_regs_tb.sv
`timescale 1ns/1ps
module pcie_linkstat2_pm_capability_regs_tb;
  import pcie_caps_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  link_phy_t phy = 2'b00;
  pwr_state_t pwr = PWR_FULL;
  logic [4:0] wake_active_states_o;
  logic wake_forward_o;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int checks = 0;
  logic [7:0] np;
  logic si;
  logic [4:0] wm;
  logic [31:0] d;
  logic [3:0] s;
  logic [11:0] zaddr [0:6] = '{12'h072, 12'h074, 12'h078, 12'h07a, 12'h004, 12'h1cc, 12'hffc};

  always #2.5 clk_i = ~clk_i;

  pcie_linkstat2_pm_capability_regs u_pcie_linkstat2_pm_capability_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .link_phy_i(phy),
    .pwr_state_i(pwr),
    .wake_active_states_o(wake_active_states_o),
    .wake_forward_o(wake_forward_o)
  );

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] m,
                     input logic [31:0] v);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= m;
    wb_wdat <= v;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      summarize();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] expv);
    exp_q.push_back(expv);
    bus(1'b0, a, 4'hf, 32'($urandom));
  endtask

  function automatic logic [31:0] pmv(input logic [7:0] p, input logic f, input logic [4:0] k);
    pmv = {k, 5'h00, f, 2'b00, 3'h3, p, 8'h01};
  endfunction

  // read results are compared against the oldest noted expectation
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(wb_dat_o, exp_q.pop_front());
    end
  end

  initial
  begin
    void'($urandom(32'h3d0a53bd));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      rd(zaddr[i], 32'h0);
      bus(1'b1, zaddr[i], 4'hf, 32'hffff_ffff);
      rd(zaddr[i], 32'h0);
    end
    rd(12'h0c0, pmv(8'hd0, 1'b0, 5'h19));
    bus(1'b1, 12'h0c0, 4'hf, 32'hffff_ffff);
    rd(12'h0c0, pmv(8'hd0, 1'b0, 5'h19));
    bus(1'b1, 12'h3c0, 4'h1, 32'h0000_0001);
    np = 8'hd0;
    si = 1'b0;
    wm = 5'h19;
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      s = 4'($urandom);
      bus(1'b1, 12'h0c0, s, d);
      if (s[1])
        np = d[15:8];
      if (s[2])
        si = d[21];
      if (s[3])
        wm = d[31:27];
      rd(12'h0c0, pmv(np, si, wm));
    end
    // wake behaviour must ignore the rewritten mask
    for (int i = 0; i < 5; i++)
    begin
      pwr <= pwr_state_t'(i);
      repeat (2) @(posedge clk_i);
      check({27'h0, wake_active_states_o}, 32'h19);
      check({31'h0, wake_forward_o}, {31'h0, (i == 0 || i == 3)});
    end
    // synchroniser settles within about five edges
    phy <= 2'b11;
    repeat (10) @(posedge clk_i);
    rd(12'h072, 32'h0001_0000);
    phy <= 2'b00;
    repeat (10) @(posedge clk_i);
    rd(12'h072, 32'h0001_0000);
    phy <= 2'b10;
    repeat (10) @(posedge clk_i);
    rd(12'h072, 32'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h0c0, pmv(8'hd0, 1'b0, 5'h19));
    bus(1'b1, 12'h0c0, 4'hf, 32'hffff_ffff);
    rd(12'h0c0, pmv(8'hd0, 1'b0, 5'h19));
    repeat (3) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule
